// >>> core/compare_wave_unit.sv
`timescale 1ns/10ps
`default_nettype none

module compare_wave_unit
    import timer8_pkg::*;
#(
    parameter bit PWM_TOGGLE_OK = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Control and events
    input wire wave_ctrl_t cfg_i,
    input wire wave_evt_t evt_i,
    // Pin
    output logic wave_o,
    output logic wave_en_o
);

    logic wave_q;
    logic wave_d;
    logic hit;
    logic set_lvl;

    // ****************************************
    // Waveform level
    // ****************************************
    always_comb begin
        wave_d = wave_q;
        set_lvl = (cfg_i.out_mode == OM_SET);
        // A compare equal to TOP is ignored in PWM; the edge moves to TOP/BOTTOM
        hit = evt_i.match & ~(cfg_i.out_mode[1] & evt_i.cmp_is_top);
        unique case (cfg_i.kind)
            KIND_PLAIN: begin
                if (evt_i.match | evt_i.force_hit) begin
                    unique case (cfg_i.out_mode)
                        OM_OFF: wave_d = wave_q;
                        OM_TOGGLE: wave_d = ~wave_q;
                        OM_CLEAR: wave_d = 1'b0;
                        OM_SET: wave_d = 1'b1;
                    endcase
                end
            end
            KIND_FAST: begin
                if (cfg_i.out_mode == OM_TOGGLE) begin
                    if (cfg_i.mode_high & PWM_TOGGLE_OK & evt_i.match) begin
                        wave_d = ~wave_q;
                    end
                end else if (cfg_i.out_mode[1]) begin
                    if (hit) begin
                        wave_d = set_lvl;
                    end else if (evt_i.bottom) begin
                        wave_d = ~set_lvl;
                    end
                end
            end
            KIND_PHASE: begin
                if (cfg_i.out_mode == OM_TOGGLE) begin
                    if (cfg_i.mode_high & PWM_TOGGLE_OK & evt_i.match) begin
                        wave_d = ~wave_q;
                    end
                end else if (cfg_i.out_mode[1]) begin
                    if (hit) begin
                        wave_d = set_lvl ^ evt_i.down;
                    end else if (evt_i.top & evt_i.cmp_is_top) begin
                        wave_d = ~set_lvl;
                    end
                end
            end
            default: wave_d = wave_q;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end

    assign wave_o = wave_q;
    assign wave_en_o = (cfg_i.out_mode != OM_OFF);

endmodule : compare_wave_unit

`default_nettype wire

// >>> core/timer8_core.sv
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Three-bit wave mode joins two control A bits with one control B bit.
// - Mode picks TOP and compare update point; modes 4 and 6 reserved.
// - Overflow flag at MAX in 0,2,3; BOTTOM in 1,5; TOP in 7.
// - Force bit in non-PWM modes forces a match on that channel's output.
// - A forced match sets no flag and never clears the counter.
// - Force bits always read back as zero.
// - Control B bits 5:4 and mask bits 7:3 read as zero.
// - Clock select: stop, undivided, 8, 64, 256, 1024, pin fall, pin rise.
// - Pin edges count even when that pin is driven as an output.
// - Count register gives direct read and write of the counter.
// - A count write blocks the compare match on the next timer clock.
// - Both compare registers compare continuously with the counter.
// - Compare B request when its enable, global enable and flag are set.
// - Compare A request when its enable, global enable and flag are set.
// - Overflow request when its enable, global enable and flag are set.
// - Flags set by events, cleared by vector ack or writing one.
// - Non-PWM output modes: off, toggle, clear, set on match.
module timer8_core
    import timer8_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // Pins
    input wire logic ext_count_pin_i,
    output logic wave_out_a_o,
    output logic wave_out_a_en_o,
    output logic wave_out_b_o,
    output logic wave_out_b_en_o,
    // Interrupts
    input wire logic global_irq_en_i,
    input wire logic [2:0] irq_ack_i,
    output logic [2:0] irq_req_o,
    output logic irq_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] ctrl_a_q;
    logic [3:0] ctrl_b_q;
    logic [2:0] mask_q;
    logic [2:0] flag_q;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [7:0] count_q;
    logic [7:0] count_d;
    count_dir_t dir_q;
    count_dir_t dir_d;
    logic [7:0] cmp_a_buf_q;
    logic [7:0] cmp_b_buf_q;
    logic [7:0] cmp_a_buf_d;
    logic [7:0] cmp_b_buf_d;
    logic [7:0] cmp_a_act_q;
    logic [7:0] cmp_b_act_q;
    logic [PRE_W-1:0] pre_q;
    logic pin_prev_q;
    logic block_q;
    logic [7:0] rdata_q;
    logic [2:0] wave_mode;
    logic [2:0] clk_sel;
    wave_kind_t kind;
    logic use_a_top;
    logic [7:0] top_val;
    logic at_top;
    logic tick;
    logic wr_ctrl_b;
    logic wr_count;
    logic match_a;
    logic match_b;
    logic ovf;
    logic force_a;
    logic force_b;
    logic cmp_upd;
    wave_ctrl_t cfg_a;
    wave_ctrl_t cfg_b;
    wave_evt_t evt_a;
    wave_evt_t evt_b;

    // ****************************************
    // Mode decode
    // ****************************************
    assign wave_mode = {ctrl_b_q[CB_WAVE_HI], ctrl_a_q[CA_WAVE_LO+1:CA_WAVE_LO]};
    assign clk_sel = ctrl_b_q[CB_CLK_LO+2:CB_CLK_LO];

    always_comb begin
        // Reserved modes run as plain counting to MAX
        kind = KIND_PLAIN;
        use_a_top = 1'b0;
        unique case (wave_mode)
            MODE_PHASE_FF: kind = KIND_PHASE;
            MODE_FAST_FF: kind = KIND_FAST;
            MODE_MATCH_CLR: use_a_top = 1'b1;
            MODE_PHASE_A: begin
                kind = KIND_PHASE;
                use_a_top = 1'b1;
            end
            MODE_FAST_A: begin
                kind = KIND_FAST;
                use_a_top = 1'b1;
            end
            default: kind = KIND_PLAIN;
        endcase
    end

    assign top_val = use_a_top ? cmp_a_act_q : MAX_VAL;
    assign at_top = (count_q == top_val);

    // ****************************************
    // Register decode
    // ****************************************
    assign wr_ctrl_b = reg_we_i & (reg_addr_i == ADDR_CTRL_B);
    assign wr_count = reg_we_i & (reg_addr_i == ADDR_COUNT);

    // Force only lands in non-PWM modes; PWM writes are expected to hold zeros
    assign force_a = wr_ctrl_b & reg_wdata_i[CB_FORCE_A] & (kind == KIND_PLAIN);
    assign force_b = wr_ctrl_b & reg_wdata_i[CB_FORCE_B] & (kind == KIND_PLAIN);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_a_q <= CTRL_RST;
        end else if (reg_we_i && reg_addr_i == ADDR_CTRL_A) begin
            ctrl_a_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_b_q <= CB_RST;
        end else if (wr_ctrl_b) begin
            // Force bits are strobes and reserved bits are not stored
            ctrl_b_q <= reg_wdata_i[3:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask_q <= IRQ_RST;
        end else if (reg_we_i && reg_addr_i == ADDR_MASK) begin
            mask_q <= reg_wdata_i[2:0];
        end
    end

    // ****************************************
    // Clock select and prescaler
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pre_q <= PRE_RST;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // Pin is sampled as a plain input, whatever drives it
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= ext_count_pin_i;
        end
    end

    always_comb begin
        tick = 1'b0;
        unique case (clk_sel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = &pre_q[DIV8_BITS-1:0];
            CS_DIV64: tick = &pre_q[DIV64_BITS-1:0];
            CS_DIV256: tick = &pre_q[DIV256_BITS-1:0];
            CS_DIV1024: tick = &pre_q[DIV1024_BITS-1:0];
            CS_EXT_FALL: tick = pin_prev_q & ~ext_count_pin_i;
            CS_EXT_RISE: tick = ~pin_prev_q & ext_count_pin_i;
        endcase
    end

    // ****************************************
    // Counter and direction
    // ****************************************
    always_comb begin
        count_d = count_q;
        dir_d = dir_q;
        if (wr_count) begin
            count_d = reg_wdata_i;
        end else if (tick) begin
            if (kind == KIND_PHASE) begin
                unique case (dir_q)
                    DIR_UP: begin
                        if (at_top) begin
                            dir_d = DIR_DOWN;
                            count_d = count_q - 8'h01;
                        end else begin
                            count_d = count_q + 8'h01;
                        end
                    end
                    DIR_DOWN: begin
                        if (count_q == BOTTOM_VAL) begin
                            dir_d = DIR_UP;
                            count_d = count_q + 8'h01;
                        end else begin
                            count_d = count_q - 8'h01;
                        end
                    end
                    default: dir_d = DIR_UP;
                endcase
            end else begin
                // Wrap after TOP; a forced match never gets here
                count_d = at_top ? BOTTOM_VAL : count_q + 8'h01;
                dir_d = DIR_UP;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_q <= CNT_RST;
            dir_q <= DIR_UP;
        end else begin
            count_q <= count_d;
            dir_q <= dir_d;
        end
    end

    // Blocks the match seen on the next timer clock after a count write
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // ****************************************
    // Compare registers
    // ****************************************
    assign cmp_a_buf_d = (reg_we_i && reg_addr_i == ADDR_CMP_A) ? reg_wdata_i : cmp_a_buf_q;
    assign cmp_b_buf_d = (reg_we_i && reg_addr_i == ADDR_CMP_B) ? reg_wdata_i : cmp_b_buf_q;

    // Immediate in plain modes, at TOP in phase modes, at wrap in fast modes
    always_comb begin
        cmp_upd = 1'b0;
        unique case (kind)
            KIND_PLAIN: cmp_upd = 1'b1;
            KIND_PHASE: cmp_upd = tick & at_top & (dir_q == DIR_UP);
            KIND_FAST: cmp_upd = tick & at_top & ~wr_count;
            default: cmp_upd = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_a_buf_q <= CMP_RST;
            cmp_b_buf_q <= CMP_RST;
        end else begin
            cmp_a_buf_q <= cmp_a_buf_d;
            cmp_b_buf_q <= cmp_b_buf_d;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_a_act_q <= CMP_RST;
            cmp_b_act_q <= CMP_RST;
        end else if (cmp_upd) begin
            cmp_a_act_q <= cmp_a_buf_d;
            cmp_b_act_q <= cmp_b_buf_d;
        end
    end

    // ****************************************
    // Match and overflow events
    // ****************************************
    assign match_a = tick & ~wr_count & ~block_q & (count_q == cmp_a_act_q);
    assign match_b = tick & ~wr_count & ~block_q & (count_q == cmp_b_act_q);

    always_comb begin
        ovf = 1'b0;
        if (tick && !wr_count) begin
            unique case (wave_mode)
                MODE_PHASE_FF, MODE_PHASE_A: ovf = (count_q == BOTTOM_VAL) & (dir_q == DIR_DOWN);
                MODE_FAST_A: ovf = at_top;
                default: ovf = (count_q == MAX_VAL);
            endcase
        end
    end

    // ****************************************
    // Waveform units
    // ****************************************
    assign cfg_a = '{kind: kind, mode_high: ctrl_b_q[CB_WAVE_HI],
                     out_mode: ctrl_a_q[CA_OUT_A_LO+1:CA_OUT_A_LO]};
    assign cfg_b = '{kind: kind, mode_high: ctrl_b_q[CB_WAVE_HI],
                     out_mode: ctrl_a_q[CA_OUT_B_LO+1:CA_OUT_B_LO]};

    assign evt_a = '{match: match_a, force_hit: force_a,
                     bottom: tick & ~wr_count & at_top & (kind == KIND_FAST),
                     top: tick & ~wr_count & at_top & (kind == KIND_PHASE),
                     cmp_is_top: (cmp_a_act_q == top_val),
                     down: (dir_q == DIR_DOWN)};
    assign evt_b = '{match: match_b, force_hit: force_b,
                     bottom: tick & ~wr_count & at_top & (kind == KIND_FAST),
                     top: tick & ~wr_count & at_top & (kind == KIND_PHASE),
                     cmp_is_top: (cmp_b_act_q == top_val),
                     down: (dir_q == DIR_DOWN)};

    compare_wave_unit #(
        .PWM_TOGGLE_OK(1'b1)
    ) u_wave_a (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .cfg_i(cfg_a),
        .evt_i(evt_a),
        .wave_o(wave_out_a_o),
        .wave_en_o(wave_out_a_en_o)
    );

    // Channel B has no toggle in PWM modes
    compare_wave_unit #(
        .PWM_TOGGLE_OK(1'b0)
    ) u_wave_b (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .cfg_i(cfg_b),
        .evt_i(evt_b),
        .wave_o(wave_out_b_o),
        .wave_en_o(wave_out_b_en_o)
    );

    // ****************************************
    // Flags and interrupts
    // ****************************************
    // Forced matches feed only the waveform units, never the flags
    assign flag_set = {match_b, match_a, ovf};

    always_comb begin
        flag_clr = irq_ack_i;
        if (reg_we_i && (reg_addr_i == ADDR_FLAGS || reg_addr_i == ADDR_FLAG_CLR)) begin
            flag_clr = irq_ack_i | reg_wdata_i[2:0];
        end
    end

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_q <= IRQ_RST;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    assign irq_req_o[FLG_B] = mask_q[FLG_B] & global_irq_en_i & flag_q[FLG_B];
    assign irq_req_o[FLG_A] = mask_q[FLG_A] & global_irq_en_i & flag_q[FLG_A];
    assign irq_req_o[FLG_OVF] = mask_q[FLG_OVF] & global_irq_en_i & flag_q[FLG_OVF];
    assign irq_o = |irq_req_o;

    // ****************************************
    // Read back
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= RD_ZERO;
        end else if (reg_re_i) begin
            unique case (reg_addr_i)
                ADDR_CTRL_A: rdata_q <= {ctrl_a_q[7:4], 2'h0, ctrl_a_q[1:0]};
                ADDR_CTRL_B: rdata_q <= {4'h0, ctrl_b_q};
                ADDR_COUNT: rdata_q <= count_q;
                ADDR_CMP_A: rdata_q <= cmp_a_buf_q;
                ADDR_CMP_B: rdata_q <= cmp_b_buf_q;
                ADDR_FLAGS: rdata_q <= {5'h00, flag_q};
                ADDR_MASK: rdata_q <= {5'h00, mask_q};
                default: rdata_q <= RD_ZERO;
            endcase
        end else begin
            rdata_q <= RD_ZERO;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule : timer8_core

`default_nettype wire

// >>> core/timer8_pkg.sv
package timer8_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_FLAGS = 8'h35;
    localparam logic [7:0] ADDR_FLAG_CLR = 8'h36;
    localparam logic [7:0] ADDR_CTRL_A = 8'h44;
    localparam logic [7:0] ADDR_CTRL_B = 8'h45;
    localparam logic [7:0] ADDR_COUNT = 8'h46;
    localparam logic [7:0] ADDR_CMP_A = 8'h47;
    localparam logic [7:0] ADDR_CMP_B = 8'h48;
    localparam logic [7:0] ADDR_MASK = 8'h6e;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CA_WAVE_LO = 0;
    localparam int CA_OUT_B_LO = 4;
    localparam int CA_OUT_A_LO = 6;
    localparam int CB_CLK_LO = 0;
    localparam int CB_WAVE_HI = 3;
    localparam int CB_FORCE_B = 6;
    localparam int CB_FORCE_A = 7;
    localparam int FLG_OVF = 0;
    localparam int FLG_A = 1;
    localparam int FLG_B = 2;

    // ****************************************
    // Reset values and fixed counter values
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [3:0] CB_RST = 4'h0;
    localparam logic [7:0] MAX_VAL = 8'hff;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // ****************************************
    // Prescaler taps
    // ****************************************
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
    localparam int DIV8_BITS = 3;
    localparam int DIV64_BITS = 6;
    localparam int DIV256_BITS = 8;
    localparam int DIV1024_BITS = 10;

    // ****************************************
    // Modes and clock selections
    // ****************************************
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PHASE_FF = 3'h1;
    localparam logic [2:0] MODE_MATCH_CLR = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PHASE_A = 3'h5;
    localparam logic [2:0] MODE_FAST_A = 3'h7;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    typedef enum logic [2:0] {
        KIND_PLAIN = 3'b001,
        KIND_FAST = 3'b010,
        KIND_PHASE = 3'b100
    } wave_kind_t;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } count_dir_t;

    typedef struct packed {
        wave_kind_t kind;
        logic mode_high;
        logic [1:0] out_mode;
    } wave_ctrl_t;

    typedef struct packed {
        logic match;
        logic force_hit;
        logic bottom;
        logic top;
        logic cmp_is_top;
        logic down;
    } wave_evt_t;

endpackage : timer8_pkg

// >>> test/eight_bit_timer_pwm_tb.sv
`timescale 1ns/10ps
`default_nettype none
module eight_bit_timer_pwm_tb;
    import timer8_pkg::*;
    logic clk, rst, we, re, pin, gie, wa, wae, wb, wbe, irq;
    logic [7:0] addr, wdata, rdata, d;
    logic [2:0] ack, req;
    int checked = 0;
    int bad_count = 0;
    int dv[4] = '{8, 64, 256, 1024};

    timer8_core DUT (.sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .ext_count_pin_i(pin), .wave_out_a_o(wa), .wave_out_a_en_o(wae),
        .wave_out_b_o(wb), .wave_out_b_en_o(wbe), .global_irq_en_i(gie),
        .irq_ack_i(ack), .irq_req_o(req), .irq_o(irq));

    // ********************
    // Bus tasks
    // ********************
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask : rdchk
    task automatic wait_irq;
        for (int i = 0; i < 300 && irq !== 1'b1; i++) step(1);
    endtask : wait_irq
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is near 5900 cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    // ********************
    // Tests
    // ********************
    initial begin
        {rst, we, re, pin, gie, ack, addr, wdata} = {1'b1, 23'h0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(ADDR_CTRL_B, 8'h00);
        rdchk(ADDR_MASK, 8'h00);
        rdchk(8'h00, 8'h00);
        $display("test reset done");
        wr(ADDR_CTRL_A, 8'h40);
        wr(ADDR_CTRL_B, 8'hf0);
        step(2);
        chk({4'h0, wbe, wb, wae, wa}, 8'h03);
        rdchk(ADDR_CTRL_B, 8'h00);
        rdchk(ADDR_FLAGS, 8'h00);
        wr(ADDR_MASK, 8'hff);
        rdchk(ADDR_MASK, 8'h07);
        wr(ADDR_COUNT, 8'h5a);
        rdchk(ADDR_COUNT, 8'h5a);
        $display("test access done");
        wr(ADDR_MASK, 8'h02);
        gie <= 1'b1;
        wr(ADDR_CMP_A, 8'h03);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL_B, 8'h01);
        wait_irq();
        chk({5'h0, req}, 8'h02);
        chk({7'h0, wa}, 8'h00);
        wr(ADDR_CTRL_B, 8'h00);
        @(posedge clk) ack <= 3'h2;
        @(posedge clk) ack <= 3'h0;
        step(1);
        chk({7'h0, irq}, 8'h00);
        $display("test match A done");
        // Counter parked away from both compare values
        wr(ADDR_MASK, 8'h04);
        wr(ADDR_CMP_B, 8'h07);
        wr(ADDR_COUNT, 8'h10);
        wr(ADDR_CTRL_B, 8'h01);
        wr(ADDR_COUNT, 8'h07);
        step(4);
        rdchk(ADDR_FLAGS, 8'h00);
        wait_irq();
        chk({5'h0, req}, 8'h04);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_FLAG_CLR, 8'h07);
        rdchk(ADDR_FLAGS, 8'h00);
        $display("test match B done");
        // Count cleared after the new select so no old-rate tick slips in
        for (int k = 2; k < 6; k++) begin
            wr(ADDR_CTRL_B, 8'(k));
            wr(ADDR_COUNT, 8'h00);
            step(4 * dv[k - 2]);
            rd(ADDR_COUNT, d);
            chk({7'h0, d inside {[3:5]}}, 8'h01);
        end
        for (int k = 6; k < 8; k++) begin
            wr(ADDR_CTRL_B, 8'(k));
            wr(ADDR_COUNT, 8'h00);
            repeat (3) begin
                @(posedge clk) pin <= 1'b1;
                step(2);
                @(posedge clk) pin <= 1'b0;
                step(2);
            end
            rdchk(ADDR_COUNT, 8'h03);
        end
        $display("test clock select done");
        wr(ADDR_FLAG_CLR, 8'h07);
        wr(ADDR_CMP_A, 8'h05);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL_A, 8'h02);
        wr(ADDR_CTRL_B, 8'h01);
        for (int i = 0; i < 6; i++) begin
            rd(ADDR_COUNT, d);
            chk({7'h0, d <= 8'h05}, 8'h01);
        end
        rd(ADDR_FLAGS, d);
        chk({7'h0, d[0]}, 8'h00);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_CTRL_A, 8'h03);
        wr(ADDR_CTRL_B, 8'h09);
        // Count may sit above the new TOP after the switch
        wr(ADDR_COUNT, 8'h00);
        step(20);
        chk({5'h0, req}, 8'h01);
        wr(ADDR_CTRL_A, 8'h01);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_FLAG_CLR, 8'h07);
        rd(ADDR_FLAGS, d);
        chk({7'h0, d[0]}, 8'h00);
        step(20);
        chk({5'h0, req}, 8'h01);
        $display("test modes done");
        end_of_test();
    end
endmodule : eight_bit_timer_pwm_tb

bind timer8_core timer8_checker u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .ext_count_pin_i(ext_count_pin_i),
    .wave_out_a_o(wave_out_a_o), .wave_out_a_en_o(wave_out_a_en_o),
    .wave_out_b_o(wave_out_b_o), .wave_out_b_en_o(wave_out_b_en_o),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
    .irq_o(irq_o));
`default_nettype wire

// >>> test/timer8_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module timer8_checker
    import timer8_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    // Pins
    input wire logic ext_count_pin_i,
    input wire logic wave_out_a_o,
    input wire logic wave_out_a_en_o,
    input wire logic wave_out_b_o,
    input wire logic wave_out_b_en_o,
    // Interrupts
    input wire logic global_irq_en_i,
    input wire logic [2:0] irq_ack_i,
    input wire logic [2:0] irq_req_o,
    input wire logic irq_o
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_RD_IDLE: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read slot");
    AST_IRQ_OR: assert property (irq_o == (|irq_req_o))
        else $error("irq line not OR of requests");
    AST_IRQ_GATE: assert property (!global_irq_en_i |-> irq_req_o == 3'h0)
        else $error("request without global enable");
    AST_REQ_STICKY: assert property (irq_req_o[0] && global_irq_en_i && !irq_ack_i[0]
        && !reg_we_i |=> irq_req_o[0] || !global_irq_en_i)
        else $error("overflow request dropped");
    AST_CB_RD: assert property (reg_re_i && reg_addr_i == ADDR_CTRL_B
        |=> reg_rdata_o[7:4] == 4'h0)
        else $error("control B upper bits not zero");
    AST_MASK_RD: assert property (reg_re_i && reg_addr_i == ADDR_MASK
        |=> reg_rdata_o[7:3] == 5'h00)
        else $error("mask reserved bits not zero");
    AST_EN_MODE: assert property (reg_we_i && reg_addr_i == ADDR_CTRL_A
        |=> wave_out_a_en_o == (($past(reg_wdata_i) & 8'hc0) != 8'h00)
        && wave_out_b_en_o == (($past(reg_wdata_i) & 8'h30) != 8'h00))
        else $error("pin enable not from output mode");
    AST_UNMAPPED: assert property (reg_re_i && reg_addr_i == 8'h00
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Main scenarios reached
    cover property ($rose(irq_o));
    cover property ($changed(wave_out_a_o));
    cover property (reg_re_i && reg_addr_i == ADDR_COUNT);
endmodule : timer8_checker
`default_nettype wire
